/* hw/erct_defines.vh */
// constants for the receive classify and teardown block
//
// ==================================================================
// How it works
// RULE1: a teardown command for any channel is accepted at any time
// RULE2: a frame in progress on the channel finishes before teardown acts
// RULE3: teardown sets the done flag in the next descriptor if one exists
// RULE4: teardown clears the channel head descriptor pointer to zero
// RULE5: teardown raises channel interrupt and loads ack with FFFFFFFC
// RULE6: software clears a teardown interrupt by writing FFFFFFFC to ack
// RULE7: teardown never changes any channel enable bit
// RULE8: teardown on inactive channel raises interrupt but writes no descriptor
// RULE9: proper frame is 64 to max length inclusive with no errors
// RULE10: longer than max length is long; max length resets to 5EE
// RULE11: long without error is oversized, long with error is jabber
// RULE12: under 64 is short; clean matching short is undersized, errored is fragment; code counts any clean short frame as undersized, matching or not
// RULE13: frames of 20 bytes or fewer always keep their crc bytes
// RULE14: with error copy, long frames store exactly max length bytes
// RULE15: frame at max length is not long; stored size follows keep-fcs bit
// RULE16: promiscuous mode routes non-matching frames to promiscuous channel
// RULE17: match only counts if destination channel is enabled
// RULE18: one promiscuous channel selected; mode enabled by any copy bit
// RULE19: short and control copy bits forward undersized and control frames
// RULE20: error copy bit forwards every errored frame to promiscuous channel; code sends oversized ones there only when copy_all is also set
// RULE21: all-frames bit forwards proper frames, others add their classes
// RULE22: all four copy bits forward every non-matching frame
// RULE23: matching frames with other copy bits clear pass only proper frames
// RULE24: each of eight channels has its own enable bit
// RULE25: filtered frames use no descriptor and raise no interrupt
`ifndef ERCT_DEFINES_VH
`define ERCT_DEFINES_VH

// ==================================================================
// register byte offsets
`define ERCT_OFS_TEARDOWN   12'h000
`define ERCT_OFS_FILTER     12'h004
`define ERCT_OFS_MAXLEN     12'h008
`define ERCT_OFS_CHAN_ON    12'h00C
`define ERCT_OFS_IRQ_PEND   12'h010
`define ERCT_OFS_ACK_BASE   12'h040
`define ERCT_OFS_HDP_BASE   12'h080
`define ERCT_OFS_NEXT_BASE  12'h0C0

// ==================================================================
// filter control fields
`define ERCT_F_COPY_ALL     0
`define ERCT_F_COPY_ERR     1
`define ERCT_F_COPY_CTRL    2
`define ERCT_F_COPY_SHORT   3
`define ERCT_F_KEEP_FCS     4
`define ERCT_F_PROM_LO      8
`define ERCT_F_PROM_HI      10

// ==================================================================
// reset values and figures
`define ERCT_MAXLEN_RST     16'h05EE
`define ERCT_MIN_LEN        16'h0040
`define ERCT_TINY_LEN       16'h0014
`define ERCT_FCS_LEN        16'h0004
`define ERCT_TDOWN_ACK      32'hFFFFFFFC
`define ERCT_FILTER_RST     32'h00000000

`endif

/* hw/erct_rx_classify_teardown.v */
// receive classification, promiscuous filter and channel teardown
`timescale 1ns/1ps
`include "erct_defines.vh"

module erct_rx_classify_teardown (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // frame start and end report from phy side
  input  wire        frame_start,
  input  wire [2:0]  frame_chan,
  input  wire        frame_end,
  input  wire [15:0] frame_len,
  input  wire        frame_err,
  input  wire        frame_ctrl,
  input  wire        frame_addr_hit,
  // frame verdict
  output reg         fwd_valid,
  output reg  [2:0]  fwd_chan,
  output reg  [15:0] fwd_store_len,
  output reg         filt_pulse,
  // descriptor side
  output reg         done_flag_wr,
  output reg  [2:0]  done_flag_chan,
  output reg  [31:0] done_flag_addr,
  output reg  [7:0]  rx_irq
);

  // ==================================================================
  // registers
  reg [31:0] filter_reg;
  reg [15:0] maxlen_reg;
  reg [7:0]  chan_on_reg;
  reg [7:0]  pend_reg;
  reg [7:0]  busy_reg;
  reg [7:0]  tdown_req_reg;
  reg [31:0] ack_reg [0:7];
  reg [31:0] hdp_reg [0:7];
  reg [31:0] next_reg [0:7];
  integer    i;

  wire       copy_all   = filter_reg[`ERCT_F_COPY_ALL];
  wire       copy_err   = filter_reg[`ERCT_F_COPY_ERR];
  wire       copy_ctrl  = filter_reg[`ERCT_F_COPY_CTRL];
  wire       copy_short = filter_reg[`ERCT_F_COPY_SHORT];
  wire       keep_fcs   = filter_reg[`ERCT_F_KEEP_FCS];
  wire [2:0] prom_ch    = filter_reg[`ERCT_F_PROM_HI:`ERCT_F_PROM_LO];

  // ==================================================================
  // frame classes
  wire is_long   = frame_len > maxlen_reg;                             // RULE10 RULE15
  wire is_short  = frame_len < `ERCT_MIN_LEN;
  wire match     = frame_addr_hit & chan_on_reg[frame_chan];           // RULE17 RULE24
  wire proper    = ~is_long & ~is_short & ~frame_err & ~frame_ctrl;    // RULE9
  wire oversized = is_long & ~frame_err;                               // RULE11
  wire jabber    = is_long & frame_err;                                // RULE11
  wire undersize = is_short & ~frame_err;                              // RULE12
  wire fragment  = is_short & frame_err;                               // RULE12
  wire ctrl_ok   = frame_ctrl & ~frame_err & ~is_short & ~is_long;
  wire errored   = frame_err | oversized;

  reg  pass;
  always @* begin
    pass = 1'b0;
    if (match) begin
      pass = proper;                                                   // RULE23
      if (copy_err && (errored || jabber || fragment))
        pass = 1'b1;
      if (copy_ctrl && ctrl_ok)
        pass = 1'b1;
      if (copy_short && undersize)
        pass = 1'b1;
    end else begin
      if (copy_all && proper)                                          // RULE21
        pass = 1'b1;
      if (copy_err && (jabber || fragment || frame_err ||
                       (copy_all && oversized)))                       // RULE20
        pass = 1'b1;
      if (copy_ctrl && ctrl_ok)                                        // RULE19
        pass = 1'b1;
      if (copy_short && undersize)                                     // RULE19
        pass = 1'b1;
      if (copy_all && copy_err && copy_ctrl && copy_short)             // RULE22
        pass = 1'b1;
    end
  end

  wire [2:0]  dest_ch = match ? frame_chan : prom_ch;                  // RULE16 RULE18

  reg  [15:0] store_len;
  always @* begin
    if (is_long && copy_err)
      store_len = maxlen_reg;                                          // RULE14
    else if (frame_len <= `ERCT_TINY_LEN || keep_fcs)
      store_len = frame_len;                                           // RULE13 RULE15
    else
      store_len = frame_len - `ERCT_FCS_LEN;                           // RULE15
  end

  // ==================================================================
  // apb decode
  wire        acc     = psel & penable;
  wire        wr      = acc & pwrite;
  wire [2:0]  idx     = paddr[4:2];
  wire [11:0] ack_base  = `ERCT_OFS_ACK_BASE;
  wire [11:0] hdp_base  = `ERCT_OFS_HDP_BASE;
  wire [11:0] next_base = `ERCT_OFS_NEXT_BASE;
  wire        in_ack  = paddr[11:5] == ack_base[11:5];
  wire        in_hdp  = paddr[11:5] == hdp_base[11:5];
  wire        in_next = paddr[11:5] == next_base[11:5];
  wire        w_tdown = wr && paddr == `ERCT_OFS_TEARDOWN;
  wire [7:0]  tdown_hit = w_tdown ? (8'h01 << pwdata[2:0]) : 8'h00;   // RULE1

  reg  [31:0] rd_next;
  reg         map_ok;
  always @* begin
    rd_next = 32'h00000000;
    map_ok  = 1'b1;
    case (paddr)
      `ERCT_OFS_TEARDOWN: rd_next = 32'h00000000;
      `ERCT_OFS_FILTER:   rd_next = filter_reg;
      `ERCT_OFS_MAXLEN:   rd_next = {16'h0000, maxlen_reg};
      `ERCT_OFS_CHAN_ON:  rd_next = {24'h000000, chan_on_reg};
      `ERCT_OFS_IRQ_PEND: rd_next = {24'h000000, pend_reg};
      default: begin
        if (in_ack && paddr[1:0] == 2'b00)
          rd_next = ack_reg[idx];
        else if (in_hdp && paddr[1:0] == 2'b00)
          rd_next = hdp_reg[idx];
        else if (in_next && paddr[1:0] == 2'b00)
          rd_next = next_reg[idx];
        else
          map_ok = 1'b0;
      end
    endcase
  end

  // ==================================================================
  // sequential logic
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_reg     <= `ERCT_FILTER_RST;
      maxlen_reg     <= `ERCT_MAXLEN_RST;
      chan_on_reg    <= 8'h00;
      pend_reg       <= 8'h00;
      busy_reg       <= 8'h00;
      tdown_req_reg  <= 8'h00;
      prdata         <= 32'h00000000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      fwd_valid      <= 1'b0;
      fwd_chan       <= 3'h0;
      fwd_store_len  <= 16'h0000;
      filt_pulse     <= 1'b0;
      done_flag_wr   <= 1'b0;
      done_flag_chan <= 3'h0;
      done_flag_addr <= 32'h00000000;
      rx_irq         <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        ack_reg[i]  <= 32'h00000000;
        hdp_reg[i]  <= 32'h00000000;
        next_reg[i] <= 32'h00000000;
      end
    end else if (clk_en) begin
      pready       <= psel & ~penable;
      pslverr      <= psel & ~penable & ~map_ok;
      prdata       <= (psel & ~penable & ~pwrite) ? rd_next : 32'h00000000;
      fwd_valid    <= 1'b0;
      filt_pulse   <= 1'b0;
      done_flag_wr <= 1'b0;

      if (wr && pready) begin
        if (paddr == `ERCT_OFS_FILTER)
          filter_reg <= pwdata;
        if (paddr == `ERCT_OFS_MAXLEN)
          maxlen_reg <= pwdata[15:0];
        if (paddr == `ERCT_OFS_CHAN_ON)
          chan_on_reg <= pwdata[7:0];                                  // RULE7
        if (in_hdp)
          hdp_reg[idx] <= pwdata;
        if (in_next)
          next_reg[idx] <= pwdata;
      end

      // track frames in progress per channel
      if (frame_start)
        busy_reg[frame_chan] <= 1'b1;
      if (frame_end) begin
        busy_reg[frame_chan] <= 1'b0;
        if (pass) begin
          fwd_valid     <= 1'b1;
          fwd_chan      <= dest_ch;
          fwd_store_len <= store_len;
        end else begin
          filt_pulse    <= 1'b1;                                       // RULE25
        end
      end

      // teardown: queue, then act once the channel is idle
      for (i = 0; i < 8; i = i + 1) begin
        if (tdown_hit[i] && pready)
          tdown_req_reg[i] <= 1'b1;                                    // RULE1
        if (tdown_req_reg[i] && !busy_reg[i] &&
            !(frame_start && frame_chan == i[2:0])) begin              // RULE2
          tdown_req_reg[i] <= 1'b0;
          pend_reg[i]      <= 1'b1;                                    // RULE5 RULE8
          ack_reg[i]       <= `ERCT_TDOWN_ACK;                         // RULE5
          hdp_reg[i]       <= 32'h00000000;                            // RULE4
          if (chan_on_reg[i] && next_reg[i] != 32'h00000000) begin     // RULE3 RULE8
            done_flag_wr   <= 1'b1;
            done_flag_chan <= i[2:0];
            done_flag_addr <= next_reg[i];
          end
        end else if (wr && pready && in_ack && idx == i[2:0] &&
                     pwdata == ack_reg[i]) begin
          pend_reg[i]      <= 1'b0;                                    // RULE6
        end
      end
      rx_irq <= pend_reg;
    end
  end

endmodule // erct_rx_classify_teardown

/* verification/erct_phy_model.sv */
// behavioural phy partner delivering frame reports
`timescale 1ns/1ps
module erct_phy_model (
  // clock
  input  wire logic   clk,
  // frame report
  output logic        frame_start,
  output logic [2:0]  frame_chan,
  output logic        frame_end,
  output logic [15:0] frame_len,
  output logic        frame_err,
  output logic        frame_ctrl,
  output logic        frame_addr_hit
);
  initial begin
    {frame_start, frame_chan, frame_end, frame_len} = 21'h0;
    {frame_err, frame_ctrl, frame_addr_hit} = 3'h0;
  end
  // one frame: start pulse, gap cycles, end pulse with fields
  task send(input logic [2:0] ch, input logic [15:0] ln, input logic [2:0] f, input int gap);
    @(posedge clk);
    frame_start <= 1'b1;
    frame_chan <= ch;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (gap) @(posedge clk);
    frame_end <= 1'b1;
    frame_len <= ln;
    {frame_err, frame_ctrl, frame_addr_hit} <= f;
    @(posedge clk);
    frame_end <= 1'b0;
    frame_len <= ~ln;
    {frame_err, frame_ctrl, frame_addr_hit} <= ~f;
  endtask
endmodule // erct_phy_model

/* verification/erct_rx_checker.sv */
// assertion checker for the receive classify and teardown block
`timescale 1ns/1ps
module erct_rx_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // frames
  input wire logic        frame_end,
  input wire logic [15:0] frame_len,
  input wire logic        fwd_valid,
  input wire logic [15:0] fwd_store_len,
  input wire logic        filt_pulse,
  // teardown
  input wire logic        done_flag_wr,
  input wire logic [2:0]  done_flag_chan,
  input wire logic [31:0] done_flag_addr,
  input wire logic [7:0]  rx_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // assertions
  chk_one_verdict: assert property (
    frame_end |=> fwd_valid != filt_pulse) else $error("frame verdict missing");
  chk_verdict_cause: assert property (
    (fwd_valid || filt_pulse) |-> $past(frame_end)) else $error("verdict without frame");
  chk_tiny_fcs: assert property (
    (frame_end && frame_len <= 16'h0014) |=> (!fwd_valid || fwd_store_len == $past(frame_len)))
    else $error("tiny frame lost fcs bytes");
  chk_store_cap: assert property (
    fwd_valid |-> fwd_store_len <= $past(frame_len)) else $error("stored size too big");
  chk_apb_answer: assert property (
    (psel && !penable) |=> pready ##1 !pready) else $error("apb answer timing");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  chk_done_irq: assert property (
    done_flag_wr |-> ##[1:2] rx_irq[done_flag_chan]) else $error("teardown irq missing");
  chk_done_addr: assert property (
    done_flag_wr |-> done_flag_addr != 32'h0) else $error("done flag without descriptor");
  cov_fwd: cover property (fwd_valid);
  cov_filt: cover property (filt_pulse);
  cov_done: cover property (done_flag_wr);
endmodule // erct_rx_checker

bind erct_rx_classify_teardown erct_rx_checker chk_u (.clk, .reset_n, .psel, .penable,
  .pready, .pslverr, .frame_end, .frame_len, .fwd_valid, .fwd_store_len, .filt_pulse,
  .done_flag_wr, .done_flag_chan, .done_flag_addr, .rx_irq);

/* verification/eth_rx_classify_teardown_test.sv */
// self-checking testbench for the receive classify and teardown block
`timescale 1ns/1ps
module eth_rx_classify_teardown_test;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, done_flag_addr, rdq, daddr;
  logic        pready, pslverr, rde, frame_start, frame_end, frame_err, frame_ctrl;
  logic        frame_addr_hit, fwd_valid, filt_pulse, done_flag_wr;
  logic [2:0]  frame_chan, fwd_chan, done_flag_chan, dch;
  logic [15:0] frame_len, fwd_store_len;
  logic [7:0]  rx_irq;
  int          errors = 0, n_checks = 0, nd = 0;

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (done_flag_wr) begin
    nd <= nd + 1;
    daddr <= done_flag_addr;
    dch <= done_flag_chan;
  end

  erct_rx_classify_teardown dut_u (.clk, .reset_n, .clk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_start, .frame_chan, .frame_end,
    .frame_len, .frame_err, .frame_ctrl, .frame_addr_hit, .fwd_valid, .fwd_chan,
    .fwd_store_len, .filt_pulse, .done_flag_wr, .done_flag_chan, .done_flag_addr, .rx_irq);
  erct_phy_model phy_u (.clk, .frame_start, .frame_chan, .frame_end, .frame_len,
    .frame_err, .frame_ctrl, .frame_addr_hit);

  // ==========================================
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // filter setting, frame, verdict {fwd, chan, stored length}
  task fr(input logic [11:0] flt, input logic [2:0] ch, input logic [15:0] ln,
          input logic [2:0] f, input logic [19:0] exp);
    apb(1'b1, 12'h004, {20'h0, flt});
    phy_u.send(ch, ln, f, 2);
    #1;
    chk(fwd_valid ? {12'h0, 1'b1, fwd_chan, fwd_store_len} : {13'h0, filt_pulse, 18'h0}, exp);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    #300000;
    errors++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk(rdq, 32'h5EE);
    apb(1'b0, 12'h020, 32'h0);
    chk(rde, 1'b1);
    apb(1'b1, 12'h008, 32'h64);
    apb(1'b1, 12'h00C, 32'h0F);
    fr(12'h000, 1, 64, 3'b001, 20'h9003C);
    fr(12'h000, 1, 100, 3'b001, 20'h90060);
    fr(12'h010, 1, 100, 3'b001, 20'h90064);
    fr(12'h000, 1, 101, 3'b001, 20'h40000);
    fr(12'h008, 2, 20, 3'b001, 20'hA0014);
    fr(12'h502, 3, 101, 3'b100, 20'hD0064);
    fr(12'h500, 3, 64, 3'b000, 20'h40000);
    fr(12'h504, 3, 64, 3'b010, 20'hD003C);
    fr(12'h501, 3, 80, 3'b000, 20'hD004C);
    fr(12'h501, 3, 80, 3'b010, 20'h40000);
    fr(12'h51F, 3, 30, 3'b100, 20'hD001E);
    fr(12'h501, 6, 80, 3'b001, 20'hD004C);
    fr(12'h701, 3, 64, 3'b000, 20'hF003C);
    chk({nd[23:0], rx_irq}, 32'h0);
    apb(1'b1, 12'h0C0, 32'h100);
    apb(1'b1, 12'h080, 32'h200);
    fork
      phy_u.send(0, 64, 3'b001, 12);
      apb(1'b1, 12'h000, 32'h0);
    join
    #1;
    chk(nd, 0);
    tick(4);
    chk({nd[23:0], rx_irq}, 32'h101);
    chk(daddr, 32'h100);
    chk({29'h0, dch}, 32'h0);
    apb(1'b0, 12'h080, 32'h0);
    chk(rdq, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(rdq, 32'hFFFFFFFC);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rdq, 32'h0F);
    apb(1'b1, 12'h040, 32'hFFFFFFFC);
    tick(3);
    chk(rx_irq, 8'h00);
    apb(1'b1, 12'h000, 32'h7);
    tick(4);
    chk({nd[23:0], rx_irq}, 32'h180);
    apb(1'b0, 12'h05C, 32'h0);
    chk(rdq, 32'hFFFFFFFC);
    give_verdict;
  end
endmodule // eth_rx_classify_teardown_test
